// [core/irq_flag_and_edge_control.sv]
// Interrupt flag groups zero and one with external pin edge polarity control
//
// Functional notes
// - Flags read 1 after a request, 0 when none pending; software reads and writes them.
// - Flag group zero bits 15 and 14 read zero and ignore writes.
// - Flag group zero bit 4 always reads zero.
// - ADC conversion complete sets group zero bit 13.
// - UART one transmit sets bit 12, receive sets bit 11 of group zero.
// - SPI one event sets bit 10, fault sets bit 9 of group zero.
// - Timers three, two, one set group zero bits 8, 7, 3.
// - Compare two sets group zero bit 6, compare one sets bit 2.
// - Capture two sets group zero bit 5, capture one sets bit 1.
// - External input zero sets group zero bit 0.
// - Timer five sets group one bit 12, timer four sets bit 11.
// - Control bits 0..4 pick edge per external input: 1 falling, 0 rising.
`timescale 1ns/1ps
`include "irq_flag_regs.svh"

module irq_flag_and_edge_control
  import irq_flag_pkg::*;
#(
  parameter int NUM_EXT = `NUM_EXT_IRQ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t req,
  output logic [`DATA_W-1:0] rdata,
  // Peripheral request pulses
  input wire periph_req_t periph,
  // External interrupt pins, asynchronous to clk
  input wire logic [NUM_EXT-1:0] ext_pin,
  // Status from the core shown live in the control register, not stored
  input wire logic irq_disable_countdown_active,
  // Control outputs
  output logic alternate_vector_select,
  output logic [`DATA_W-1:0] flags_zero,
  output logic [`DATA_W-1:0] flags_one
);

  logic [`DATA_W-1:0] flags_zero_q;
  logic [`DATA_W-1:0] flags_one_q;
  logic [`DATA_W-1:0] set_zero;
  logic [`DATA_W-1:0] set_one;
  logic [NUM_EXT-1:0] edge_polarity_q;
  logic alt_vector_q;
  logic [NUM_EXT-1:0] sync_a_q;
  logic [NUM_EXT-1:0] sync_b_q;
  logic [NUM_EXT-1:0] sync_c_q;
  logic [NUM_EXT-1:0] ext_edge;
  logic [`DATA_W-1:0] rdata_q;
  logic wr_control;
  logic wr_zero;
  logic wr_one;
  logic rd_control;
  logic rd_zero;
  logic rd_one;
  logic [NUM_EXT-1:0] rise_edge;
  logic [NUM_EXT-1:0] fall_edge;
  logic [`DATA_W-1:0] flags_zero_d;
  logic [`DATA_W-1:0] flags_one_d;
  logic [`DATA_W-1:0] control_view;
  logic [`DATA_W-1:0] rdata_d;

  // Address decode shared by the write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction : hit

  // Next flag word: a write replaces the word, then requests are ORed on top,
  // so a request landing in the clearing cycle is never lost
  function automatic logic [`DATA_W-1:0] flag_next(
    input logic [`DATA_W-1:0] cur,
    input logic [`DATA_W-1:0] wdata,
    input logic wr,
    input logic [`DATA_W-1:0] set,
    input logic [`DATA_W-1:0] mask
  );
    logic [`DATA_W-1:0] base;
    base = wr ? wdata : cur;
    return (base | set) & mask;
  endfunction : flag_next

  // Write strobes per register
  assign wr_control = req.wr && hit(req.addr, `OFF_CONTROL_TWO);
  assign wr_zero = req.wr && hit(req.addr, `OFF_FLAGS_ZERO);
  assign wr_one = req.wr && hit(req.addr, `OFF_FLAGS_ONE);

  // Read strobes per register; any other place reads as zero
  assign rd_control = req.rd && hit(req.addr, `OFF_CONTROL_TWO);
  assign rd_zero = req.rd && hit(req.addr, `OFF_FLAGS_ZERO);
  assign rd_one = req.rd && hit(req.addr, `OFF_FLAGS_ONE);

  // First synchroniser stage; may go metastable, so only the second reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a_q <= '0;
    end else begin
      sync_a_q <= ext_pin;
    end
  end

  // Second stage gives a settled pin level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_b_q <= '0;
    end else begin
      sync_b_q <= sync_a_q;
    end
  end

  // History stage for edge detection
  // Costs one clock of latency, but keeps the detector off the first stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_c_q <= '0;
    end else begin
      sync_c_q <= sync_b_q;
    end
  end

  // Raw edges between the settled level and its history
  // Reset clears both stages, so a pin idling low gives no false edge
  assign rise_edge = sync_b_q & ~sync_c_q;
  assign fall_edge = sync_c_q & ~sync_b_q;

  // Falling edge when polarity is 1, rising when 0
  // Inputs three and four get polarity only; their flags live elsewhere
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_edge[i] = edge_polarity_q[i] ? fall_edge[i] : rise_edge[i];
    end
  end

  // Set vector for flag group zero
  always_comb begin
    set_zero = '0;
    // Converter and first UART
    set_zero[`POS_F0_ADC] = periph.adc_done;
    set_zero[`POS_F0_UART1_TX] = periph.uart_one_tx;
    set_zero[`POS_F0_UART1_RX] = periph.uart_one_rx;
    // First SPI unit
    set_zero[`POS_F0_SPI1_EVENT] = periph.spi_one_event;
    set_zero[`POS_F0_SPI1_FAULT] = periph.spi_one_fault;
    // Timers
    set_zero[`POS_F0_TIMER3] = periph.timer_three;
    set_zero[`POS_F0_TIMER2] = periph.timer_two;
    set_zero[`POS_F0_TIMER1] = periph.timer_one;
    // Compare and capture channels
    set_zero[`POS_F0_COMPARE2] = periph.compare_two;
    set_zero[`POS_F0_COMPARE1] = periph.compare_one;
    set_zero[`POS_F0_CAPTURE2] = periph.capture_two;
    set_zero[`POS_F0_CAPTURE1] = periph.capture_one;
    // External input zero
    set_zero[`POS_F0_EXT0] = ext_edge[0];
  end

  // Set vector for flag group one
  always_comb begin
    set_one = '0;
    // Second UART
    set_one[`POS_F1_UART2_TX] = periph.uart_two_tx;
    set_one[`POS_F1_UART2_RX] = periph.uart_two_rx;
    // Timers
    set_one[`POS_F1_TIMER5] = periph.timer_five;
    set_one[`POS_F1_TIMER4] = periph.timer_four;
    // Compare and capture channels
    set_one[`POS_F1_COMPARE4] = periph.compare_four;
    set_one[`POS_F1_COMPARE3] = periph.compare_three;
    set_one[`POS_F1_CAPTURE8] = periph.capture_eight;
    set_one[`POS_F1_CAPTURE7] = periph.capture_seven;
    // External inputs one and two
    set_one[`POS_F1_EXT2] = ext_edge[2];
    set_one[`POS_F1_EXT1] = ext_edge[1];
    // Change notice, comparator and I2C
    set_one[`POS_F1_PIN_CHANGE] = periph.pin_change;
    set_one[`POS_F1_COMPARATOR] = periph.comparator;
    set_one[`POS_F1_I2C1_MASTER] = periph.i2c_one_master;
    set_one[`POS_F1_I2C1_SLAVE] = periph.i2c_one_slave;
  end

  // Next values of both groups; bits outside the masks never leave zero
  // Software may also set a flag by writing 1, which raises a request
  assign flags_zero_d = flag_next(flags_zero_q, req.wdata, wr_zero, set_zero,
                                  `FLAGS_ZERO_MASK);
  assign flags_one_d = flag_next(flags_one_q, req.wdata, wr_one, set_one,
                                 `FLAGS_ONE_MASK);

  // Flag group zero register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_zero_q <= `RESET_WORD;
    end else begin
      flags_zero_q <= flags_zero_d;
    end
  end

  // Flag group one register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_one_q <= `RESET_WORD;
    end else begin
      flags_one_q <= flags_one_d;
    end
  end

  // Alternate vector select, a plain software bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alt_vector_q <= 1'b0;
    end else if (wr_control) begin
      alt_vector_q <= req.wdata[`POS_ALT_VECTOR];
    end
  end

  // Edge polarity per external input
  // Changing it while a pin moves may lose that one edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_polarity_q <= '0;
    end else if (wr_control) begin
      edge_polarity_q <= req.wdata[NUM_EXT-1:0];
    end
  end

  // Control word as software sees it
  // The countdown bit is live core status and cannot be written
  always_comb begin
    control_view = `RESET_WORD;
    control_view[NUM_EXT-1:0] = edge_polarity_q;
    control_view[`POS_ALT_VECTOR] = alt_vector_q;
    control_view[`POS_IRQ_DISABLE_COUNTDOWN_ACTIVE_ACTIVE] = irq_disable_countdown_active;
  end

  // Read select; unmapped places and idle cycles give zero
  always_comb begin
    rdata_d = `RESET_WORD;
    if (rd_control) begin
      rdata_d = control_view;
    end else if (rd_zero) begin
      rdata_d = flags_zero_q;
    end else if (rd_one) begin
      rdata_d = flags_one_q;
    end
  end

  // Read data one cycle after the strobe, zero in every other cycle
  // A zero idle value lets several slaves share one OR-ed read bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `RESET_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata = rdata_q;
  assign alternate_vector_select = alt_vector_q;
  assign flags_zero = flags_zero_q;
  assign flags_one = flags_one_q;

endmodule : irq_flag_and_edge_control

// [pkg/irq_flag_pkg.sv]
// Types shared by the interrupt flag and edge control block
package irq_flag_pkg;

  // Register bus request from the processor core
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // One-cycle request pulses from the peripherals
  typedef struct packed {
    logic adc_done;
    logic uart_one_tx;
    logic uart_one_rx;
    logic spi_one_event;
    logic spi_one_fault;
    logic timer_one;
    logic timer_two;
    logic timer_three;
    logic timer_four;
    logic timer_five;
    logic compare_one;
    logic compare_two;
    logic compare_three;
    logic compare_four;
    logic capture_one;
    logic capture_two;
    logic capture_seven;
    logic capture_eight;
    logic uart_two_tx;
    logic uart_two_rx;
    logic pin_change;
    logic comparator;
    logic i2c_one_master;
    logic i2c_one_slave;
  } periph_req_t;

endpackage : irq_flag_pkg

// [pkg/irq_flag_regs.svh]
// Register offsets, field positions and reset values of the flag and edge control block
`ifndef IRQ_FLAG_REGS_SVH
`define IRQ_FLAG_REGS_SVH

`define ADDR_W 4
`define DATA_W 16
`define OFF_CONTROL_TWO 4'h0
`define OFF_FLAGS_ZERO 4'h2
`define OFF_FLAGS_ONE 4'h4
`define RESET_WORD 16'h0000
// Implemented bits of the flag registers; the control mask omits read-only bit 14
`define FLAGS_ZERO_MASK 16'h3fef
`define FLAGS_ONE_MASK 16'hfedf
`define CONTROL_TWO_MASK 16'h801f
// Field positions
`define POS_ALT_VECTOR 15
`define POS_IRQ_DISABLE_COUNTDOWN_ACTIVE_ACTIVE 14
`define NUM_EXT_IRQ 5
`define POS_F0_EXT0 0
`define POS_F1_EXT1 4
`define POS_F1_EXT2 13
// Peripheral flag positions in group zero
`define POS_F0_ADC 13
`define POS_F0_UART1_TX 12
`define POS_F0_UART1_RX 11
`define POS_F0_SPI1_EVENT 10
`define POS_F0_SPI1_FAULT 9
`define POS_F0_TIMER3 8
`define POS_F0_TIMER2 7
`define POS_F0_COMPARE2 6
`define POS_F0_CAPTURE2 5
`define POS_F0_TIMER1 3
`define POS_F0_COMPARE1 2
`define POS_F0_CAPTURE1 1
// Peripheral flag positions in group one
`define POS_F1_UART2_TX 15
`define POS_F1_UART2_RX 14
`define POS_F1_TIMER5 12
`define POS_F1_TIMER4 11
`define POS_F1_COMPARE4 10
`define POS_F1_COMPARE3 9
`define POS_F1_CAPTURE8 7
`define POS_F1_CAPTURE7 6
`define POS_F1_PIN_CHANGE 3
`define POS_F1_COMPARATOR 2
`define POS_F1_I2C1_MASTER 1
`define POS_F1_I2C1_SLAVE 0

`endif

// [verification/ext_pin_source.sv]
// Model of the external interrupt pins driven off the clock grid
`timescale 1ns/1ps
module ext_pin_source (
  // Requested levels
  input wire logic [4:0] level,
  // Pin levels seen by the block
  output logic [4:0] ext_pin
);
  initial ext_pin = 5'h00;
  // Pins move 7 ns late, so they never line up with a clock edge
  always @(level) begin
    ext_pin <= #7 level;
  end
endmodule : ext_pin_source

// [verification/irq_flag_asserts.sv]
// Assertion checker for the interrupt flag and edge control block
`timescale 1ns/1ps
`include "irq_flag_regs.svh"
module irq_flag_checker
  import irq_flag_pkg::*;
#(parameter int NUM_EXT = `NUM_EXT_IRQ) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t req,
  input wire logic [`DATA_W-1:0] rdata,
  // Requests
  input wire periph_req_t periph,
  input wire logic [NUM_EXT-1:0] ext_pin,
  input wire logic irq_disable_countdown_active,
  // Outputs
  input wire logic alternate_vector_select,
  input wire logic [`DATA_W-1:0] flags_zero,
  input wire logic [`DATA_W-1:0] flags_one
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Clearing write with no competing pulse
  sequence s_clear;
    req.wr && req.addr == `OFF_FLAGS_ZERO && req.wdata == 16'h0000 && periph == '0
      && $past(ext_pin, 2) == $past(ext_pin, 3);
  endsequence
  property p_clear; s_clear |=> flags_zero == 16'h0000; endproperty
  property p_idle; !$past(req.rd) |-> rdata == 16'h0000; endproperty
  property p_unmap; req.rd && req.addr == 4'h6 |=> rdata == 16'h0000; endproperty
  property p_unimpl; flags_zero[15:14] == 2'h0 && !flags_zero[4]; endproperty
  property p_adc; periph.adc_done |=> flags_zero[13]; endproperty
  property p_uart; periph.uart_one_tx |=> flags_zero[12]; endproperty
  property p_timer; periph.timer_one |=> flags_zero[3]; endproperty
  property p_t5; periph.timer_five |=> flags_one[12]; endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  a_idle: assert property (p_idle) else $error("read data outside slot");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_unimpl: assert property (p_unimpl) else $error("unused bit set");
  a_adc: assert property (p_adc) else $error("adc flag missing");
  a_uart: assert property (p_uart) else $error("uart flag missing");
  a_timer: assert property (p_timer) else $error("timer flag missing");
  a_t5: assert property (p_t5) else $error("timer five flag missing");
endmodule : irq_flag_checker
bind irq_flag_and_edge_control irq_flag_checker #(.NUM_EXT(NUM_EXT)) irq_flag_checker_inst (
  .clk(clk), .rst(rst), .req(req), .rdata(rdata), .periph(periph), .ext_pin(ext_pin),
  .irq_disable_countdown_active(irq_disable_countdown_active),
  .alternate_vector_select(alternate_vector_select),
  .flags_zero(flags_zero), .flags_one(flags_one));

// [verification/testbench.sv]
// Self-checking bench for the interrupt flag and edge control block
`timescale 1ns/1ps
`include "irq_flag_regs.svh"
module testbench;
  import irq_flag_pkg::*;
  logic clk = 0;
  logic rst = 1;
  reg_req_t req = '0;
  periph_req_t periph = '0;
  logic [4:0] level = '0;
  logic [4:0] ext_pin;
  logic countdown = 0;
  logic [15:0] rdata;
  logic [15:0] got;
  logic [15:0] fz;
  logic [15:0] fo;
  logic avs;
  int bad_count = 0;
  int checked = 0;
  // Flag position of each request in struct order, plus 16 for group one
  int pos [24] = '{13, 12, 11, 10, 9, 3, 7, 8, 27, 28, 2, 6, 25, 26, 1, 5,
    22, 23, 31, 30, 19, 18, 17, 16};
  int epos [3] = '{0, 20, 29};
  always #12.5 clk = ~clk;
  ext_pin_source ext_pin_source_inst (.level(level), .ext_pin(ext_pin));
  irq_flag_and_edge_control irq_flag_and_edge_control_inst (.clk(clk), .rst(rst),
    .req(req), .rdata(rdata), .periph(periph), .ext_pin(ext_pin),
    .irq_disable_countdown_active(countdown), .alternate_vector_select(avs),
    .flags_zero(fz), .flags_one(fo));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One register cycle; read data stand only in the following cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req <= '0;
    #1 got = rdata;
  endtask : bus
  task automatic read_flag(input int p, input string n);
    bus(0, p < 16 ? `OFF_FLAGS_ZERO : `OFF_FLAGS_ONE, '0);
    chk(n, got, 16'h0001 << (p % 16));
    chk("flag output", p < 16 ? fz : fo, 16'h0001 << (p % 16));
  endtask : read_flag
  task automatic clear_all;
    bus(1, `OFF_FLAGS_ZERO, '0);
    bus(1, `OFF_FLAGS_ONE, '0);
  endtask : clear_all
  // Reset values, implemented bits, unmapped place
  task automatic test_regs;
    for (int a = 0; a < 6; a += 2) begin
      bus(0, 4'(a), '0);
      chk("reset value", got, 16'h0000);
    end
    countdown <= 1;
    bus(1, `OFF_FLAGS_ZERO, 16'hffff);
    bus(0, `OFF_FLAGS_ZERO, '0);
    chk("flags zero bits", got, 16'h3fef);
    chk("flags zero out", fz, 16'h3fef);
    bus(1, `OFF_FLAGS_ONE, 16'hffff);
    bus(0, `OFF_FLAGS_ONE, '0);
    chk("flags one bits", got, 16'hfedf);
    chk("flags one out", fo, 16'hfedf);
    bus(1, `OFF_CONTROL_TWO, 16'hffff);
    bus(0, `OFF_CONTROL_TWO, '0);
    chk("control bits", got, 16'hc01f);
    chk("alt vector out", {15'h0000, avs}, 16'h0001);
    bus(1, 4'h6, 16'hffff);
    bus(0, 4'h6, '0);
    chk("unmapped", got, 16'h0000);
    countdown <= 0;
    bus(1, `OFF_CONTROL_TWO, '0);
    // Polarity flips alone set no flags, since edges come from the pin history; wait a few cycles before clearing anyway
    repeat (4) @(posedge clk);
    clear_all;
    $display("test_regs done");
  endtask : test_regs
  task automatic test_sources;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      periph <= periph_req_t'(24'h800000 >> i);
      @(posedge clk);
      periph <= '0;
      read_flag(pos[i], "source flag");
      clear_all;
    end
    $display("test_sources done");
  endtask : test_sources
  // Selected edge sets the flag, opposite edge does not
  task automatic test_edges;
    for (int pol = 0; pol < 2; pol++) begin
      for (int i = 0; i < 3; i++) begin
        bus(1, `OFF_CONTROL_TWO, pol ? 16'h001f : 16'h0000);
        @(posedge clk);
        level <= pol ? 5'h1f : 5'h00;
        repeat (4) @(posedge clk);
        clear_all;
        @(posedge clk);
        level[i] <= !pol;
        repeat (4) @(posedge clk);
        read_flag(epos[i], "edge flag");
        clear_all;
        @(posedge clk);
        level[i] <= pol[0];
        repeat (4) @(posedge clk);
        bus(0, epos[i] < 16 ? `OFF_FLAGS_ZERO : `OFF_FLAGS_ONE, '0);
        chk("wrong edge", got, 16'h0000);
      end
    end
    $display("test_edges done");
  endtask : test_edges
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    test_regs;
    test_sources;
    test_edges;
    print_verdict;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
endmodule : testbench
